//--- rtl/aidis_consts.svh
`ifndef AIDIS_CONSTS_SVH
`define AIDIS_CONSTS_SVH
`define AIDIS_OFS_FAULT 4'h0
`define AIDIS_OFS_CLASS 4'h1
`define AIDIS_OFS_RSVD 4'h2
`define AIDIS_OFS_LOSS 4'h3
`define AIDIS_OFS_CHTYPE 4'h4
`define AIDIS_OFS_BITS 4'h5
`define AIDIS_OFS_COUNT 4'h6
`define AIDIS_OFS_CHERR 4'h7
`define AIDIS_OFS_CH0 4'h8
`define AIDIS_RST_FAULT 8'h00
`define AIDIS_RST_CLASS 8'h15
`define AIDIS_RST_CHTYPE 8'h71
`define AIDIS_RST_BITS 8'h08
`define AIDIS_RST_COUNT 8'h08
`define AIDIS_MOD_CLASS 4'h5
`define AIDIS_BIT_MODERR 0
`define AIDIS_BIT_CHERR 3
`define AIDIS_BIT_NOSUP 4
`define AIDIS_BIT_PARAM 7
`define AIDIS_BIT_LOST 6
`define AIDIS_BIT_CFG 0
`define AIDIS_BIT_UNDER 6
`define AIDIS_BIT_OVER 7
`define AIDIS_BIT_EOC 3
`define AIDIS_VAL_HIGH 16'h7FFF
`define AIDIS_VAL_LOW 16'h8000
`endif

//--- rtl/aidis_pkg.sv
package aidis_pkg;
   typedef logic [7:0] aidis_byte_t;
   typedef logic [15:0] aidis_word_t;
endpackage : aidis_pkg

//--- rtl/aidis_top.sv
`timescale 1ns/1ns
`include "aidis_consts.svh"
// How it works
// - Enabled diagnostics interrupt on listed errors.
// - Diagnostic interrupt on error entry and exit.
// - Overflow, config error, no supply give 7FFFh.
// - Underflow gives 8000h.
// - Fault lamp lit only with diagnostics enabled.
// - Basic four-byte record sent on error.
// - Extended sixteen-byte record repeats basic record.
// - Record frozen until handler completes.
// - Byte 0 holds module fault summary bits.
// - Byte 1 class 0101, channel info flag.
// - Byte 3 bit 6 flags lost interrupt.
// - Byte 4 channel type 71h.
// - Bytes 5 and 6 hold 08h.
// - Byte 7 per-channel error flags.
// - Bytes 8-15 per-channel config, under, over.
// - Process interrupts: limits and end of cycle.
// - Recording modes suppress process interrupts.
// - Base address offered with process interrupt.
// - Process data bytes 0,1 limit flags.
// - Process data byte 2 bit 3 end of cycle.
module aidis_top #(
   parameter int NCH = 8,
   parameter logic [15:0] BASE_ADDR = 16'h0000
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic diag_en_i,
   input wire logic recording_mode_i,
   input wire logic [NCH-1:0] ch_cfg_err_i,
   input wire logic [NCH-1:0] ch_over_i,
   input wire logic [NCH-1:0] ch_under_i,
   input wire logic supply_missing_i,
   input wire logic [NCH-1:0] meas_valid_i,
   input wire aidis_pkg::aidis_word_t meas_value_i [NCH],
   input wire logic [NCH-1:0] limit_hi_i,
   input wire logic [NCH-1:0] limit_lo_i,
   input wire logic cycle_done_i,
   input wire logic hi_irq_en_i,
   input wire logic lo_irq_en_i,
   input wire logic eoc_irq_en_i,
   input wire logic diag_done_i,
   input wire logic proc_ack_i,
   input wire logic [3:0] rd_addr_i,
   output aidis_pkg::aidis_byte_t rd_data_o,
   output aidis_pkg::aidis_word_t value_o [NCH],
   output logic diag_irq_o,
   output logic diag_coming_o,
   output logic proc_irq_o,
   output logic [31:0] proc_data_o,
   output logic [15:0] proc_base_o,
   output logic group_fault_o
);
   import aidis_pkg::*;

   aidis_byte_t chan_diag [NCH];
   aidis_byte_t frozen [16];
   aidis_byte_t live [16];
   logic diag_busy;
   logic err_prev;
   logic lost;
   logic proc_pend;
   logic [NCH-1:0] ch_err;
   logic any_err;
   logic err_change;
   logic [NCH-1:0] hi_hit;
   logic [NCH-1:0] lo_hit;
   logic eoc_hit;
   logic proc_event;
   logic lost_set;
   logic cfg_any;
   logic chan_any;
   logic diag_release;
   logic proc_take;
   logic proc_clear;
   logic [31:0] proc_word;
   aidis_byte_t rd_next;
   logic fault_next;

   function automatic aidis_word_t subst(input logic hi, input logic lo, input aidis_word_t v);
      if (hi) return `AIDIS_VAL_HIGH;
      if (lo) return `AIDIS_VAL_LOW;
      return v;
   endfunction : subst

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : gch
         assign chan_diag[g] = {ch_over_i[g], ch_under_i[g], 5'b0_0000, ch_cfg_err_i[g]};
         assign ch_err[g] = ch_over_i[g] | ch_under_i[g] | ch_cfg_err_i[g];
         assign live[8+g] = chan_diag[g];
         always_ff @(posedge clk_i) begin
            if (!rstn_i) begin
               value_o[g] <= 16'h0000;
            end else if (meas_valid_i[g]) begin
               value_o[g] <= subst(ch_over_i[g] | ch_cfg_err_i[g] | supply_missing_i, ch_under_i[g],
                  meas_value_i[g]);
            end
         end
      end
   endgenerate

   assign cfg_any = |ch_cfg_err_i;
   assign chan_any = |ch_err;
   // A lost process interrupt is itself a diagnostic event, so it counts as an error here.
   assign any_err = chan_any | supply_missing_i | lost;
   // Byte 0: module error, channel error, supply, wrong parameters.
   assign live[0] = {cfg_any, 2'b00, supply_missing_i, chan_any, 2'b00, any_err};
   // Channel information is always supplied, so byte 1 keeps its fixed value.
   assign live[1] = `AIDIS_RST_CLASS;
   assign live[2] = 8'h00;
   assign live[3] = {1'b0, lost, 6'b00_0000};
   assign live[4] = `AIDIS_RST_CHTYPE;
   assign live[5] = `AIDIS_RST_BITS;
   assign live[6] = `AIDIS_RST_COUNT;
   assign live[7] = ch_err;

   assign err_change = diag_en_i && (any_err != err_prev) && !diag_busy;
   assign hi_hit = hi_irq_en_i ? limit_hi_i : '0;
   assign lo_hit = lo_irq_en_i ? limit_lo_i : '0;
   assign eoc_hit = eoc_irq_en_i & cycle_done_i;
   assign proc_event = !recording_mode_i && ((|hi_hit) || (|lo_hit) || eoc_hit);
   assign lost_set = proc_event && proc_pend && !proc_ack_i;
   assign diag_release = diag_busy && diag_done_i;
   assign proc_take = proc_event && (!proc_pend || proc_ack_i);
   assign proc_clear = proc_ack_i && !proc_take;
   assign proc_word = {8'h00, 4'h0, eoc_hit, 3'b000, lo_hit, hi_hit};
   assign rd_next = diag_busy ? frozen[rd_addr_i] : live[rd_addr_i];
   assign fault_next = diag_en_i & any_err;

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         err_prev <= 1'b0;
         diag_busy <= 1'b0;
         diag_irq_o <= 1'b0;
         diag_coming_o <= 1'b0;
         for (int i = 0; i < 16; i++) frozen[i] <= 8'h00;
      end else if (err_change) begin
         err_prev <= any_err;
         diag_busy <= 1'b1;
         diag_irq_o <= 1'b1;
         diag_coming_o <= any_err;
         for (int i = 0; i < 16; i++) frozen[i] <= live[i];
      end else if (diag_release) begin
         diag_busy <= 1'b0;
         diag_irq_o <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         proc_pend <= 1'b0;
         proc_irq_o <= 1'b0;
         proc_data_o <= 32'h0000_0000;
         proc_base_o <= 16'h0000;
         lost <= 1'b0;
      end else begin
         if (lost_set) begin
            lost <= 1'b1;
         end else if (err_change) begin
            lost <= 1'b0;
         end
         if (proc_take) begin
            proc_pend <= 1'b1;
            proc_irq_o <= 1'b1;
            proc_data_o <= proc_word;
            proc_base_o <= BASE_ADDR;
         end else if (proc_clear) begin
            proc_pend <= 1'b0;
            proc_irq_o <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         rd_data_o <= 8'h00;
         group_fault_o <= 1'b0;
      end else begin
         rd_data_o <= rd_next;
         group_fault_o <= fault_next;
      end
   end

   diag_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      diag_busy && !diag_done_i |=> $stable(frozen[0]) && $stable(frozen[7]))
      else $error("record changed");
   diag_raise_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      err_change |=> diag_irq_o && diag_coming_o == $past(any_err))
      else $error("diag irq missing");
   diag_disable_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !diag_en_i |-> !err_change)
      else $error("diag without enable");
   fault_lamp_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      group_fault_o |-> $past(diag_en_i))
      else $error("lamp without enable");
   proc_mute_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      recording_mode_i && !proc_pend |=> !proc_irq_o)
      else $error("irq in recording");
   proc_base_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      $rose(proc_irq_o) |-> proc_base_o == BASE_ADDR)
      else $error("base missing");
   lost_flag_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      lost_set |=> lost)
      else $error("lost not set");
   class_byte_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      live[1][3:0] == 4'h5 && live[4] == 8'h71)
      else $error("fixed bytes wrong");
   chan_err_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      live[7] != 8'h00 |-> live[0][0] && live[0][3])
      else $error("summary wrong");

   // Record layout checks.
   rec_basic_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      diag_busy |-> frozen[1] == 8'h15)
      else $error("class byte not kept");
   rsvd_byte_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      live[2] == 8'h00 && live[3][5:0] == 6'b00_0000 && !live[3][7])
      else $error("reserved bits set");
   count_bytes_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      live[5] == 8'h08 && live[6] == 8'h08)
      else $error("count bytes wrong");
   type_flag_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !live[4][7])
      else $error("more types flag set");
   ch0_map_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      live[8][7] == ch_over_i[0] && live[8][6] == ch_under_i[0] && live[8][0] == ch_cfg_err_i[0])
      else $error("channel 0 byte wrong");
   ch7_map_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      live[15][7] == ch_over_i[NCH-1] && live[15][6] == ch_under_i[NCH-1] && live[15][0] == ch_cfg_err_i[NCH-1])
      else $error("channel 7 byte wrong");
   chan_rsvd_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      live[8][5:1] == 5'b0_0000 && live[15][5:1] == 5'b0_0000)
      else $error("channel reserved bits set");
   chan_flag_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      live[7][0] == (ch_over_i[0] | ch_under_i[0] | ch_cfg_err_i[0]))
      else $error("channel flag wrong");
   sum_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      live[7] == 8'h00 && !supply_missing_i && !lost |-> !live[0][0])
      else $error("module error stuck");
   param_flag_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      live[0][7] == (|ch_cfg_err_i))
      else $error("parameter flag wrong");
   supply_flag_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      live[0][4] == supply_missing_i)
      else $error("supply flag wrong");
   lost_byte_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      live[3][6] == lost)
      else $error("lost bit wrong");

   // Substituted measured values.
   over_value_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      meas_valid_i[0] && ch_over_i[0] |=> value_o[0] == 16'h7FFF)
      else $error("overflow value wrong");
   supply_value_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      meas_valid_i[0] && supply_missing_i |=> value_o[0] == 16'h7FFF)
      else $error("supply value wrong");
   under_value_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      meas_valid_i[0] && ch_under_i[0] && !ch_over_i[0] && !ch_cfg_err_i[0] && !supply_missing_i
      |=> value_o[0] == 16'h8000)
      else $error("underflow value wrong");
   value_pass_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      meas_valid_i[0] && !ch_over_i[0] && !ch_under_i[0] && !ch_cfg_err_i[0] && !supply_missing_i
      |=> value_o[0] == $past(meas_value_i[0]))
      else $error("value not passed");
   value_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !meas_valid_i[0] |=> $stable(value_o[0]))
      else $error("value changed");
   ch7_value_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      meas_valid_i[NCH-1] && ch_over_i[NCH-1] |=> value_o[NCH-1] == 16'h7FFF)
      else $error("channel 7 value wrong");

   // Diagnostic interrupt, record freeze and fault lamp.
   diag_release_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      diag_release |=> !diag_irq_o && !diag_busy)
      else $error("diag irq not released");
   diag_stay_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      diag_irq_o && !diag_done_i |=> diag_irq_o)
      else $error("diag irq dropped");
   diag_idle_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !diag_busy |-> !diag_irq_o)
      else $error("diag irq while idle");
   coming_stable_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      diag_busy && !diag_done_i |=> $stable(diag_coming_o))
      else $error("direction changed");
   rec_full_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      diag_busy && !diag_done_i |=> $stable(frozen[3]) && $stable(frozen[8]) && $stable(frozen[15]))
      else $error("extended record changed");
   rd_frozen_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      diag_busy |=> rd_data_o == $past(frozen[rd_addr_i]))
      else $error("read not frozen");
   diag_capture_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      err_change |=> frozen[0] == $past(live[0]) && frozen[7] == $past(live[7]))
      else $error("record not captured");
   diag_lost_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      diag_en_i && lost && !err_prev && !diag_busy |-> err_change)
      else $error("lost without diag");
   lamp_on_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      diag_en_i && any_err |=> group_fault_o)
      else $error("lamp not lit");
   lamp_off_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !diag_en_i |=> !group_fault_o)
      else $error("lamp lit");

   // Process interrupt checks.
   proc_raise_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      proc_event && !proc_pend |=> proc_irq_o)
      else $error("proc irq missing");
   proc_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      proc_irq_o && !proc_ack_i |=> proc_irq_o)
      else $error("proc irq dropped");
   proc_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      proc_clear |=> !proc_irq_o)
      else $error("proc irq not cleared");
   hi_mute_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !hi_irq_en_i |-> hi_hit == '0)
      else $error("upper source not gated");
   lo_mute_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !lo_irq_en_i |-> lo_hit == '0)
      else $error("lower source not gated");
   eoc_mute_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !eoc_irq_en_i |-> !eoc_hit)
      else $error("cycle source not gated");
   proc_hi_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      proc_take |=> proc_data_o[7:0] == ($past(hi_irq_en_i) ? $past(limit_hi_i) : 8'h00))
      else $error("upper flags wrong");
   proc_lo_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      proc_take |=> proc_data_o[15:8] == ($past(lo_irq_en_i) ? $past(limit_lo_i) : 8'h00))
      else $error("lower flags wrong");
   proc_eoc_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      proc_take && eoc_irq_en_i && cycle_done_i |=> proc_data_o[19])
      else $error("cycle flag missing");
   proc_rsvd_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      proc_irq_o |-> proc_data_o[31:20] == 12'h000 && proc_data_o[18:16] == 3'b000)
      else $error("proc reserved bits set");
   mute_event_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      recording_mode_i |-> !proc_event)
      else $error("event while recording");
   base_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      proc_irq_o |-> proc_base_o == BASE_ADDR)
      else $error("base not held");
   lost_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      lost && !err_change |=> lost)
      else $error("lost flag dropped");
endmodule : aidis_top

//--- verification/aidis_host_model.sv
`timescale 1ns/1ns
// Host side: completes the diagnostic handler and acknowledges process interrupts after DLY cycles.
// While hold_i is high the host stays busy and answers nothing.
module aidis_host_model #(parameter int DLY = 5) (
   input wire logic clk_i,
   input wire logic hold_i,
   input wire logic diag_irq_i,
   input wire logic proc_irq_i,
   output logic diag_done_o,
   output logic proc_ack_o
);
   int dc = 0;
   int pc = 0;
   initial begin
      diag_done_o = 1'b0;
      proc_ack_o = 1'b0;
   end
   // Answers change just after a rising edge, so the block sees them settled at the next one.
   always @(posedge clk_i) begin
      if (diag_irq_i === 1'b1 && !diag_done_o && !hold_i) begin
         dc <= dc + 1;
         diag_done_o <= (dc == DLY - 1);
      end else begin
         dc <= 0;
         diag_done_o <= 1'b0;
      end
      if (proc_irq_i === 1'b1 && !proc_ack_o && !hold_i) begin
         pc <= pc + 1;
         proc_ack_o <= (pc == DLY - 1);
      end else begin
         pc <= 0;
         proc_ack_o <= 1'b0;
      end
   end
endmodule : aidis_host_model

//--- verification/tb_analog_input_diag_interrupt_status.sv
`timescale 1ns/1ns
module tb_analog_input_diag_interrupt_status;
   logic clk = 0, rstn = 0, den = 0, rec = 0, sup = 0, cyc = 0, hien = 0, loen = 0, eocen = 0, hold = 0;
   logic [7:0] cfg = 0, ovr = 0, und = 0, mval = 0, lhi = 0, llo = 0;
   logic [3:0] addr = 0;
   aidis_pkg::aidis_word_t mv [8] = '{default: 16'h0123};
   aidis_pkg::aidis_word_t vals [8];
   aidis_pkg::aidis_byte_t rdat;
   logic dirq, dcom, pirq, gf, done, ack;
   logic [31:0] pdat;
   logic [15:0] pbase;
   int error_cnt = 0, checked = 0;
   logic [11:0] rows [8] = '{12'h0_00, 12'h1_15, 12'h2_00, 12'h3_00, 12'h4_71, 12'h5_08, 12'h6_08, 12'h7_00};
   aidis_top #(.BASE_ADDR(16'h1230)) u_dut (.clk_i(clk), .rstn_i(rstn), .diag_en_i(den), .recording_mode_i(rec),
      .ch_cfg_err_i(cfg),
      .ch_over_i(ovr), .ch_under_i(und), .supply_missing_i(sup), .meas_valid_i(mval), .meas_value_i(mv),
      .limit_hi_i(lhi), .limit_lo_i(llo), .cycle_done_i(cyc), .hi_irq_en_i(hien), .lo_irq_en_i(loen),
      .eoc_irq_en_i(eocen), .diag_done_i(done), .proc_ack_i(ack), .rd_addr_i(addr), .rd_data_o(rdat),
      .value_o(vals), .diag_irq_o(dirq), .diag_coming_o(dcom), .proc_irq_o(pirq), .proc_data_o(pdat),
      .proc_base_o(pbase), .group_fault_o(gf));
   aidis_host_model u_host (.clk_i(clk), .hold_i(hold), .diag_irq_i(dirq), .proc_irq_i(pirq),
      .diag_done_o(done), .proc_ack_o(ack));
   initial begin
      forever #4 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask : step
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      addr = a;
      step(2);
      chk("record byte", rdat, exp);
   endtask : rd
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   initial begin
      #100000;
      error_cnt++;
      complete_run();
   end
   initial begin
      step(3);
      chk("diag irq in reset", dirq, 0);
      chk("proc irq in reset", pirq, 0);
      rstn = 1;
      foreach (rows[i]) rd(rows[i][11:8], rows[i][7:0]);
      $display("test defaults done");
      den = 1;
      hold = 1;
      ovr = 8'h01;
      mval = 8'hff;
      step(1);
      mval = 0;
      step(1);
      chk("diag irq", dirq, 1);
      chk("coming", dcom, 1);
      chk("value 0", vals[0], 16'h7fff);
      chk("value 1", vals[1], 16'h0123);
      chk("group fault", gf, 1);
      rd(4'h8, 8'h80);
      rd(4'h7, 8'h01);
      ovr = 0;
      rd(4'h0, 8'h09);
      rd(4'h1, 8'h15);
      hold = 0;
      step(6);
      chk("diag irq done", dirq, 0);
      step(1);
      chk("going", dcom, 0);
      chk("diag irq going", dirq, 1);
      step(10);
      chk("group fault off", gf, 0);
      $display("test overflow done");
      den = 0;
      und = 8'h08;
      cfg = 8'h04;
      mval = 8'hff;
      step(1);
      mval = 0;
      step(1);
      chk("value 3", vals[3], 16'h8000);
      chk("value 2", vals[2], 16'h7fff);
      chk("no lamp", gf, 0);
      chk("no diag irq", dirq, 0);
      rd(4'ha, 8'h01);
      und = 0;
      cfg = 0;
      sup = 1;
      mval = 8'h40;
      step(1);
      mval = 0;
      step(1);
      chk("value 6", vals[6], 16'h7fff);
      sup = 0;
      $display("test underflow done");
      hien = 1;
      eocen = 1;
      hold = 1;
      lhi = 8'h04;
      step(1);
      lhi = 0;
      step(1);
      chk("proc irq", pirq, 1);
      chk("proc data", pdat, 32'h0000_0004);
      chk("base", pbase, 16'h1230);
      cyc = 1;
      step(1);
      cyc = 0;
      rd(4'h3, 8'h40);
      hold = 0;
      step(10);
      chk("proc irq acked", pirq, 0);
      cyc = 1;
      step(1);
      cyc = 0;
      step(1);
      chk("eoc data", pdat, 32'h0008_0000);
      step(10);
      rec = 1;
      lhi = 8'h01;
      step(1);
      lhi = 0;
      step(2);
      chk("muted", pirq, 0);
      rec = 0;
      loen = 1;
      hold = 1;
      llo = 8'h02;
      step(1);
      llo = 0;
      step(1);
      chk("lower data", pdat, 32'h0000_0200);
      $display("test process irq done");
      den = 1;
      step(2);
      chk("lost diag irq", dirq, 1);
      chk("lost coming", dcom, 1);
      rd(4'h3, 8'h40);
      $display("test lost irq done");
      complete_run();
   end
endmodule : tb_analog_input_diag_interrupt_status
